// ===== smc_cmp_model.sv
/*
 * Behavioural supply comparator on the analog side of the monitor.
 * Assumes the bench sets the supply in millivolts.
 */
`timescale 1ns/100ps
module smc_cmp_model (
	// Control from the monitor
	input  wire smc_pkg::smc_ana_t ana_ctrl,
	// Supply level and result
	input  wire logic signed [31:0] vdd_mv,
	output logic                   cmp_below
);
	import smc_pkg::*;
	int thr_mv;

	// Nominal trip voltage for each level code
	always_comb begin
		case (ana_ctrl.level_sel)
			2'h0: thr_mv = 2200;
			2'h1: thr_mv = 2700;
			2'h2: thr_mv = 3800;
			default: thr_mv = 4500;
		endcase
	end

	// Comparator output is low while it is switched off
	assign cmp_below = ana_ctrl.detect_en & (vdd_mv < thr_mv);
endmodule // smc_cmp_model

// ===== smc_defines.svh
/*
 * Register offsets, field positions, reset values and timing figures for the
 * supply monitor control block.
 * Assumes a 50 MHz system clock and word-aligned AHB-Lite register access.
 */
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// Register byte offsets
`define SMC_OFF_POWER_CONTROL_REG      8'hA0
`define SMC_OFF_PMC       8'hAC
`define SMC_OFF_RSR       8'hB0
`define SMC_OFF_TA        8'hB4
`define SMC_OFF_CFG       8'hB8
`define SMC_OFF_IEN       8'hBC

// Field positions
`define SMC_POWER_CONTROL_REG_COLD     4
`define SMC_PMC_BOS       0
`define SMC_PMC_LOWPOWER_DETECT_ENABLE     2
`define SMC_PMC_BOF       3
`define SMC_PMC_BROWNOUT_RESET_ENABLE     4
`define SMC_PMC_BROWNOUT_DETECT_ENABLE     7
`define SMC_RSR_BROWNOUT_RESET_CAUSE      2
`define SMC_CFG_LVL_LO    0
`define SMC_IEN_BROWNOUT_IRQ_ENABLE      2
`define SMC_IEN_EA        7

// Reset values
`define SMC_PMC_BROWNOUT_DETECT_ENABLE_RST 1'b1
`define SMC_PMC_BROWNOUT_RESET_ENABLE_RST 1'b0
`define SMC_PMC_LP_RST    1'b0
`define SMC_CFG_LVL_RST   2'h0

// Timed-access unlock keys and window
`define SMC_TA_KEY1       8'hAA
`define SMC_TA_KEY2       8'h55
`define SMC_TA_WINDOW     4'h8

// Timing figures
`define SMC_CLK_MHZ       50
`define SMC_LP_INTERVAL_US 12800
`define SMC_BOR_HOLD_US   8000

`endif

// ===== smc_pkg.sv
/*
 * Types of the supply monitor control block.
 * Assumes smc_defines.svh supplies the numeric constants.
 */
package smc_pkg;

	// Signals sent to the analog supply comparator
	typedef struct packed {
		logic       detect_en;
		logic [1:0] level_sel;
		logic       lp_osc_en;
	} smc_ana_t;

	// Timed-access unlock sequence
	typedef enum logic [1:0] {
		SMC_TA_LOCKED,
		SMC_TA_HALF,
		SMC_TA_OPEN
	} smc_ta_t;

endpackage

// ===== smc_supply_monitor.sv
/*
 * Supply monitor control: cold-start flag, brown-out event, status and reset
 * cause, low-power sampled detection, timed-access protected control register,
 * all behind an AHB-Lite slave with one wait state.
 * Assumes hresetn is the power-on reset and the comparator input is
 * asynchronous to hclk.
 */
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "smc_defines.svh"

// Behaviour
// - Power-on sets cold-start flag
// - Cold-start flag cleared only by software; event flag also cleared by disabling detection
// - Two-bit field selects one of four levels
// - Drop below level resets or interrupts
// - Reset disabled: drop sets event flag
// - No re-set while supply stays low
// - Recovery above level also sets flag
// - Status bit shows present comparator state
// - Reset enabled: drop resets, sets cause
// - Cause survives non-power-on resets, software clears
// - Low-power mode samples once per interval
// - Normal mode evaluates comparator continuously
// - Low-power bit needs detection enabled
// - Disabled detection holds status, flag zero
// - Interrupt needs both enable bits set
module smc_supply_monitor #(
	parameter int LP_CYCLES  = `SMC_LP_INTERVAL_US * `SMC_CLK_MHZ,
	parameter int BOR_CYCLES = `SMC_BOR_HOLD_US * `SMC_CLK_MHZ
) (
	// Clock and power-on reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [7:0]        haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// Analog comparator
	input  wire logic              cmp_below,
	output smc_pkg::smc_ana_t      ana_ctrl,
	// Processor interrupt and reset
	output logic                   brownout_irq,
	output logic                   brownout_reset_req
);
	import smc_pkg::*;

	localparam int CW = 20;

	logic              hreadyout_r;
	logic [31:0]       hrdata_r;
	logic              pend_r;
	logic              pend_wr_r;
	logic [7:0]        pend_addr_r;
	logic              cmp_s1_r;
	logic              cmp_s2_r;
	logic              sample_r;
	logic              level_r;
	logic              level_d_r;
	logic [CW-1:0]     lp_cnt_r;
	logic              lp_tick;
	logic              lp_eff;
	logic              cold_start_flag_r;
	logic              brownout_detect_enable_r;
	logic              brownout_reset_enable_r;
	logic              lowpower_detect_enable_r;
	logic              brownout_event_flag_r;
	logic              brownout_reset_cause_r;
	logic [1:0]        brownout_level_sel_r;
	logic              brownout_irq_enable_r;
	logic              global_irq_enable_r;
	smc_ta_t           ta_state_r;
	logic [3:0]        ta_cnt_r;
	logic              irq_r;
	logic              bor_req_r;
	logic [CW-1:0]     bor_cnt_r;
	smc_ana_t          ana_r;
	logic              wr_now;
	logic [7:0]        wbyte;
	logic              drop_ev;
	logic              edge_ev;

	// Write of a given register in the current data phase
	function automatic logic is_wr(input logic [7:0] off);
		return pend_r && pend_wr_r && (pend_addr_r == off);
	endfunction

	assign wr_now  = pend_r && pend_wr_r;
	assign wbyte   = hwdata[7:0];
	assign lp_eff  = brownout_detect_enable_r && lowpower_detect_enable_r;
	assign lp_tick = (lp_cnt_r == CW'(LP_CYCLES - 1));
	assign edge_ev = level_r ^ level_d_r;
	assign drop_ev = level_r && !level_d_r;

	// Bus slave: capture address phase, answer after one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_r      <= 1'b0;
			pend_wr_r   <= 1'b0;
			pend_addr_r <= 8'h00;
			hreadyout_r <= 1'b1;
		end else if (!pend_r && hsel && hready && htrans[1]) begin
			pend_r      <= 1'b1;
			pend_wr_r   <= hwrite;
			pend_addr_r <= {haddr[7:2], 2'b00};
			hreadyout_r <= 1'b0;
		end else begin
			pend_r      <= 1'b0;
			hreadyout_r <= 1'b1;
		end
	end

	// Read data, loaded in the wait cycle; unmapped offsets read zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (pend_r && !pend_wr_r) begin
			case (pend_addr_r)
				`SMC_OFF_POWER_CONTROL_REG: hrdata_r <= {27'h0, cold_start_flag_r, 4'h0};
				`SMC_OFF_PMC:  hrdata_r <= {24'h0, brownout_detect_enable_r, 2'b00, brownout_reset_enable_r,
					brownout_event_flag_r, lowpower_detect_enable_r, 1'b0, level_r};
				`SMC_OFF_RSR:  hrdata_r <= {29'h0, brownout_reset_cause_r, 2'b00};
				`SMC_OFF_TA:   hrdata_r <= {31'h0, ta_state_r == SMC_TA_OPEN};
				`SMC_OFF_CFG:  hrdata_r <= {30'h0, brownout_level_sel_r};
				`SMC_OFF_IEN:  hrdata_r <= {24'h0, global_irq_enable_r, 4'h0, brownout_irq_enable_r, 2'b00};
				default:       hrdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Timed-access unlock: two keys, then a short window for one write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ta_state_r <= SMC_TA_LOCKED;
			ta_cnt_r   <= 4'h0;
		end else begin
			case (ta_state_r)
				SMC_TA_LOCKED: begin
					if (is_wr(`SMC_OFF_TA) && wbyte == `SMC_TA_KEY1)
						ta_state_r <= SMC_TA_HALF;
				end
				SMC_TA_HALF: begin
					if (is_wr(`SMC_OFF_TA) && wbyte == `SMC_TA_KEY2) begin
						ta_state_r <= SMC_TA_OPEN;
						ta_cnt_r   <= `SMC_TA_WINDOW;
					end else if (wr_now) begin
						ta_state_r <= SMC_TA_LOCKED;
					end
				end
				SMC_TA_OPEN: begin
					ta_cnt_r <= ta_cnt_r - 4'h1;
					if (is_wr(`SMC_OFF_PMC) || ta_cnt_r == 4'h1)
						ta_state_r <= SMC_TA_LOCKED;
				end
				default: ta_state_r <= SMC_TA_LOCKED;
			endcase
		end
	end

	// Protected control bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			brownout_detect_enable_r <= `SMC_PMC_BROWNOUT_DETECT_ENABLE_RST;
			brownout_reset_enable_r  <= `SMC_PMC_BROWNOUT_RESET_ENABLE_RST;
			lowpower_detect_enable_r <= `SMC_PMC_LP_RST;
		end else if (is_wr(`SMC_OFF_PMC) && ta_state_r == SMC_TA_OPEN) begin
			brownout_detect_enable_r <= wbyte[`SMC_PMC_BROWNOUT_DETECT_ENABLE];
			brownout_reset_enable_r  <= wbyte[`SMC_PMC_BROWNOUT_RESET_ENABLE];
			lowpower_detect_enable_r <= wbyte[`SMC_PMC_LOWPOWER_DETECT_ENABLE];
		end
	end

	// Level select and interrupt enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			brownout_level_sel_r  <= `SMC_CFG_LVL_RST;
			brownout_irq_enable_r <= 1'b0;
			global_irq_enable_r   <= 1'b0;
		end else begin
			if (is_wr(`SMC_OFF_CFG))
				brownout_level_sel_r <= wbyte[`SMC_CFG_LVL_LO +: 2];
			if (is_wr(`SMC_OFF_IEN)) begin
				brownout_irq_enable_r <= wbyte[`SMC_IEN_BROWNOUT_IRQ_ENABLE];
				global_irq_enable_r   <= wbyte[`SMC_IEN_EA];
			end
		end
	end

	// Comparator synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
		end else begin
			cmp_s1_r <= cmp_below;
			cmp_s2_r <= cmp_s1_r;
		end
	end

	// Low-power interval counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			lp_cnt_r <= '0;
		else if (!lp_eff || lp_tick)
			lp_cnt_r <= '0;
		else
			lp_cnt_r <= lp_cnt_r + CW'(1);
	end

	// Sampling: continuous in normal mode, once per interval in low power
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sample_r <= 1'b0;
		else if (!lp_eff)
			sample_r <= cmp_s2_r;
		else if (lp_tick)
			sample_r <= cmp_s2_r;
	end

	// Effective below-level state, forced low while detection is off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_r   <= 1'b0;
			level_d_r <= 1'b0;
		end else begin
			level_r   <= brownout_detect_enable_r && sample_r;
			level_d_r <= level_r;
		end
	end

	// Event flag: set on drop and on recovery, set wins over software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			brownout_event_flag_r <= 1'b0;
		else if (!brownout_detect_enable_r)
			brownout_event_flag_r <= 1'b0;
		else if (edge_ev)
			brownout_event_flag_r <= 1'b1;
		else if (is_wr(`SMC_OFF_PMC) && !wbyte[`SMC_PMC_BOF])
			brownout_event_flag_r <= 1'b0;
	end

	// Cold-start flag: set by power-on reset, cleared by software only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cold_start_flag_r <= 1'b1;
		else if (is_wr(`SMC_OFF_POWER_CONTROL_REG) && !wbyte[`SMC_POWER_CONTROL_REG_COLD])
			cold_start_flag_r <= 1'b0;
	end

	// Reset cause: only power-on clears it in hardware
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			brownout_reset_cause_r <= 1'b0;
		else if (drop_ev && brownout_reset_enable_r)
			brownout_reset_cause_r <= 1'b1;
		else if (is_wr(`SMC_OFF_RSR) && !wbyte[`SMC_RSR_BROWNOUT_RESET_CAUSE])
			brownout_reset_cause_r <= 1'b0;
	end

	// Brown-out reset request, held for the reset time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bor_req_r <= 1'b0;
			bor_cnt_r <= '0;
		end else if (drop_ev && brownout_reset_enable_r) begin
			bor_req_r <= 1'b1;
			bor_cnt_r <= CW'(BOR_CYCLES - 1);
		end else if (bor_cnt_r != '0) begin
			bor_cnt_r <= bor_cnt_r - CW'(1);
		end else begin
			bor_req_r <= 1'b0;
		end
	end

	// Interrupt request gated by both enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_r <= 1'b0;
		else
			irq_r <= brownout_event_flag_r && !brownout_reset_enable_r
				&& brownout_irq_enable_r && global_irq_enable_r;
	end

	// Comparator controls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ana_r <= '0;
		end else begin
			ana_r.detect_en <= brownout_detect_enable_r;
			ana_r.level_sel <= brownout_level_sel_r;
			ana_r.lp_osc_en <= lp_eff;
		end
	end

	// Outputs straight from flops, hresp tied low
	assign hreadyout          = hreadyout_r;
	assign hresp              = 1'b0;
	assign hrdata             = hrdata_r;
	assign ana_ctrl           = ana_r;
	assign brownout_irq       = irq_r;
	assign brownout_reset_req = bor_req_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_off_holds_zero: assert property (!brownout_detect_enable_r ##1 !brownout_detect_enable_r
		|-> !brownout_event_flag_r && !level_r) else $error("flag or status set while disabled");
	chk_edge_sets_flag: assert property (edge_ev && brownout_detect_enable_r
		|=> brownout_event_flag_r) else $error("transition did not set event flag");
	chk_flag_sw_clear: assert property ($fell(brownout_event_flag_r)
		|-> $past(wr_now && pend_addr_r == `SMC_OFF_PMC) || $past(!brownout_detect_enable_r))
		else $error("flag cleared by hardware");
	chk_cold_sw_clear: assert property ($fell(cold_start_flag_r) |-> $past(wr_now && pend_addr_r == `SMC_OFF_POWER_CONTROL_REG))
		else $error("cold flag cleared without write");
	chk_drop_resets: assert property (drop_ev && brownout_reset_enable_r
		|=> bor_req_r && brownout_reset_cause_r ##1 bor_req_r) else $error("drop did not request reset");
	chk_irq_gating: assert property (brownout_irq |-> $past(global_irq_enable_r)
		&& $past(brownout_irq_enable_r)) else $error("interrupt without both enables");
	chk_irq_raise: assert property (brownout_event_flag_r && brownout_irq_enable_r && global_irq_enable_r
		&& !brownout_reset_enable_r |=> brownout_irq) else $error("interrupt not raised");
	chk_lp_sample_hold: assert property (lp_eff && !lp_tick |=> $stable(sample_r))
		else $error("sample moved between ticks");
	chk_ta_guard: assert property (wr_now && pend_addr_r == `SMC_OFF_PMC && ta_state_r != SMC_TA_OPEN
		|=> $stable(brownout_reset_enable_r) && $stable(lowpower_detect_enable_r)) else $error("locked write took");
	chk_bus_wait: assert property (!pend_r && hsel && hready && htrans[1]
		|=> !hreadyout ##1 hreadyout) else $error("bus answer timing wrong");
	chk_cause_sticky: assert property ($fell(brownout_reset_cause_r)
		|-> $past(wr_now && pend_addr_r == `SMC_OFF_RSR)) else $error("reset cause cleared without write");
	chk_status_follow: assert property (brownout_detect_enable_r
		|=> level_r == $past(sample_r)) else $error("status does not follow comparator");
	chk_no_irq_reset: assert property (brownout_reset_enable_r
		|=> !brownout_irq) else $error("interrupt raised in reset mode");
	chk_normal_cont: assert property (!lp_eff
		|=> sample_r == $past(cmp_s2_r)) else $error("normal mode did not sample every cycle");

endmodule // smc_supply_monitor

// ===== smc_supply_monitor_tb_top.sv
/*
 * Self-checking bench for the supply monitor control block.
 * Assumes the comparator model and short interval counts.
 */
`timescale 1ns/100ps
`include "smc_defines.svh"
module smc_supply_monitor_tb_top;
	import smc_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, cmp_below;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic        hreadyout, hresp, brownout_irq, brownout_reset_req;
	smc_ana_t    ana_ctrl;
	int          vdd_mv, err_total, compares, cyc, n;

	// Design with short sampling and reset counts
	smc_supply_monitor #(.LP_CYCLES(16), .BOR_CYCLES(8)) dut_u (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.cmp_below(cmp_below), .ana_ctrl(ana_ctrl), .brownout_irq(brownout_irq),
		.brownout_reset_req(brownout_reset_req));

	// Analog partner
	smc_cmp_model cmp_u (.ana_ctrl(ana_ctrl), .vdd_mv(vdd_mv), .cmp_below(cmp_below));

	// Clock
	always #10 hclk = ~hclk;

	// Hang guard
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			print_verdict();
		end
	end

	task print_verdict;
		$display("Compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One single AHB-Lite transfer, entered just after a rising edge
	task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(a, 1'b0, 32'h0);
		check(what, rd, exp);
	endtask

	// Control write behind the unlock keys
	task pmc_w(input logic [31:0] d);
		bus(`SMC_OFF_TA, 1'b1, {24'h0, `SMC_TA_KEY1});
		bus(`SMC_OFF_TA, 1'b1, {24'h0, `SMC_TA_KEY2});
		bus(`SMC_OFF_PMC, 1'b1, d);
	endtask

	// Wait bounded for an output level, then compare it
	task wait_sig(input int mx, input bit rst, input logic exp, input string what);
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while ((rst ? brownout_reset_req : brownout_irq) !== exp && n < mx);
		check(what, rst ? brownout_reset_req : brownout_irq, exp);
		@(posedge hclk);
	endtask

	// Main sequence
	initial begin
		{hclk, hresetn, hsel, hwrite, haddr, htrans, hwdata, err_total, compares, cyc} = '0;
		hsize = 3'h2;
		vdd_mv = 5000;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(`SMC_OFF_POWER_CONTROL_REG, 32'h10, "cold");
		rd_chk(`SMC_OFF_PMC, 32'h80, "pmc_idle");
		bus(`SMC_OFF_POWER_CONTROL_REG, 1'b1, 32'h0);
		rd_chk(`SMC_OFF_POWER_CONTROL_REG, 32'h0, "cold_clr");
		for (int l = 0; l < 4; l++) begin
			bus(`SMC_OFF_CFG, 1'b1, l);
			@(posedge hclk);
			check("level", ana_ctrl.level_sel, l);
		end
		bus(`SMC_OFF_IEN, 1'b1, 32'h84);
		vdd_mv <= 4000;
		wait_sig(8, 0, 1'b1, "irq_drop");
		check("no_rst", brownout_reset_req, 1'b0);
		rd_chk(`SMC_OFF_PMC, 32'h89, "pmc_drop");
		bus(`SMC_OFF_PMC, 1'b1, 32'h80);
		repeat (10) @(posedge hclk);
		rd_chk(`SMC_OFF_PMC, 32'h81, "pmc_low");
		check("irq_low", brownout_irq, 1'b0);
		vdd_mv <= 5000;
		wait_sig(8, 0, 1'b1, "irq_rise");
		rd_chk(`SMC_OFF_PMC, 32'h88, "pmc_rise");
		bus(`SMC_OFF_PMC, 1'b1, 32'h80);
		bus(`SMC_OFF_IEN, 1'b1, 32'h04);
		vdd_mv <= 4000;
		repeat (10) @(posedge hclk);
		rd_chk(`SMC_OFF_PMC, 32'h89, "pmc_noga");
		check("irq_noga", brownout_irq, 1'b0);
		bus(`SMC_OFF_IEN, 1'b1, 32'h84);
		wait_sig(4, 0, 1'b1, "irq_ga");
		vdd_mv <= 5000;
		repeat (10) @(posedge hclk);
		bus(`SMC_OFF_PMC, 1'b1, 32'h90);
		rd_chk(`SMC_OFF_PMC, 32'h80, "pmc_lock");
		pmc_w(32'h90);
		rd_chk(`SMC_OFF_PMC, 32'h90, "pmc_open");
		vdd_mv <= 4000;
		wait_sig(8, 1, 1'b1, "rst_req");
		n = 1;
		while (brownout_reset_req === 1'b1 && n < 20) begin
			@(negedge hclk);
			n++;
		end
		check("rst_len", n, 9);
		check("irq_rst", brownout_irq, 1'b0);
		@(posedge hclk);
		rd_chk(`SMC_OFF_RSR, 32'h04, "cause");
		bus(`SMC_OFF_RSR, 1'b1, 32'h0);
		rd_chk(`SMC_OFF_RSR, 32'h0, "cause_clr");
		vdd_mv <= 5000;
		repeat (10) @(posedge hclk);
		pmc_w(32'h84);
		@(posedge hclk);
		check("lp_osc", ana_ctrl.lp_osc_en, 1'b1);
		rd_chk(`SMC_OFF_PMC, 32'h84, "pmc_lp");
		vdd_mv <= 4000;
		wait_sig(40, 0, 1'b1, "irq_lp");
		pmc_w(32'h04);
		@(posedge hclk);
		check("ana_off", ana_ctrl, {1'b0, 2'h3, 1'b0});
		rd_chk(`SMC_OFF_PMC, 32'h04, "pmc_off");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(`SMC_OFF_POWER_CONTROL_REG, 32'h10, "cold_again");
		print_verdict();
	end
endmodule // smc_supply_monitor_tb_top
